// [or_move_pointer_load_exec.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: decode and execute of literal-or, file-or, pointer-load and file-copy
// Assumes: one instruction word offered per cycle, sampled in the first quarter
// Notes: each instruction cycle is four clocks, one per quarter
//////////////////////////////////////////////////////////////////////////////
// Function
// - literal-or ORs the 8-bit immediate into the accumulator, sets N and Z.
// - 0001 00 d a f decodes as accumulator OR addressed register.
// - file-or destination bit 0 writes accumulator, 1 writes the register.
// - bank bit 0 uses fixed access region, 1 uses the bank select register.
// - file-or updates N and Z only, other flags untouched.
// - pointer-load puts 12-bit immediate into pointer chosen by 2-bit index.
// - pointer-load is two words: 1110 1110 00 ii kkkk then 1111 0000 kkkkkkkk.
// - pointer-load leaves every status flag unchanged.
// - 0101 00 d a f copies the register to destination, sets N and Z.
// - the 8-bit file address reaches any location of the 256-byte bank.
//
// Our own choices: the address map and the strobed register port.
module or_move_pointer_load_exec
	import or_move_pointer_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic [REG_AW-1:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic [1:0] o_quarter,
	output logic o_second_word,
	output logic [7:0] o_wreg,
	output logic [ST_W-1:0] o_status,
	output logic [3:0] o_bank_select,
	output ptr_bank_t o_ptr
);
	function automatic op_t decode_op(input logic [15:0] w);
		if (w[15:8] == LIT_OR_HI) return OP_LIT_OR;
		else if (w[15:10] == FILE_OR_HI) return OP_FILE_OR;
		else if (w[15:10] == FILE_COPY_HI) return OP_FILE_COPY;
		else if (w[15:6] == PTR_LOAD_HI) return OP_PTR_LOAD;
		else return OP_NONE;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// state
	logic [1:0] qtr, next_qtr;
	logic [15:0] ir, next_ir;
	logic ir_valid, next_ir_valid;
	seq_t seq, next_seq;
	logic [1:0] ptr_idx, next_ptr_idx;
	logic [7:0] result, next_result;
	logic [ADDR_W-1:0] eff_addr, next_eff_addr;
	logic [7:0] wreg, next_wreg;
	logic [ST_W-1:0] status, next_status;
	logic [3:0] bank_select_register, next_bank_select_register;
	ptr_bank_t ptr, next_ptr;
	logic [ADDR_W-1:0] maddr, next_maddr;
	logic [7:0] rdata, next_rdata;

	op_t cur_op;
	file_instr_t fi;
	logic is_file_op;
	logic [7:0] mem_rd;
	logic mem_re;
	logic mem_we;
	logic bus_mem_we;
	logic [ADDR_W-1:0] addr_calc;

	assign fi = ir;
	assign cur_op = (seq == SEQ_FIRST && ir_valid) ? decode_op(ir) : OP_NONE;
	assign is_file_op = (cur_op == OP_FILE_OR) || (cur_op == OP_FILE_COPY);
	assign mem_re = (qtr == QTR_2) && is_file_op;
	assign mem_we = (qtr == QTR_4) && fi.dest && is_file_op;
	assign bus_mem_we = i_reg_wr && (i_reg_addr == REG_MDATA);

	// full 8-bit offset inside a 256-byte bank
	always_comb begin
		if (!fi.bank) begin
			addr_calc = {(fi.faddr < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, fi.faddr};
		end else begin
			addr_calc = {bank_select_register, fi.faddr};
		end
	end

	data_store #(.AW(ADDR_W), .DW(DATA_W)) u_store (
		.i_clk(i_sys_clk),
		.i_rd_en(mem_re),
		.i_rd_addr(addr_calc),
		.o_rd_data(mem_rd),
		.i_wa_en(mem_we),
		.i_wa_addr(eff_addr),
		.i_wa_data(result),
		.i_wb_en(bus_mem_we),
		.i_wb_addr(maddr),
		.i_wb_data(i_reg_wdata)
	);

	//////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_qtr = qtr + 2'h1;
		next_ir = ir;
		next_ir_valid = ir_valid;
		next_seq = seq;
		next_ptr_idx = ptr_idx;
		next_result = result;
		next_eff_addr = eff_addr;
		next_wreg = wreg;
		next_status = status;
		next_bank_select_register = bank_select_register;
		next_ptr = ptr;
		next_maddr = maddr;
		next_rdata = 8'h00;
		// register port writes, core writes below take priority
		if (i_reg_wr) begin
			case (i_reg_addr)
				REG_BANK: next_bank_select_register = i_reg_wdata[3:0];
				REG_W: next_wreg = i_reg_wdata;
				REG_STATUS: next_status = i_reg_wdata[ST_W-1:0];
				REG_MADDR_LO: next_maddr[7:0] = i_reg_wdata;
				REG_MADDR_HI: next_maddr[11:8] = i_reg_wdata[3:0];
				default: ;
			endcase
		end
		if (i_reg_rd) begin
			case (i_reg_addr)
				REG_BANK: next_rdata = {4'h0, bank_select_register};
				REG_W: next_rdata = wreg;
				REG_STATUS: next_rdata = {3'h0, status};
				REG_MADDR_LO: next_rdata = maddr[7:0];
				REG_MADDR_HI: next_rdata = {4'h0, maddr[11:8]};
				default: begin
					if (i_reg_addr >= REG_PTR0_HI && i_reg_addr <= REG_PTR2_LO) begin
						next_rdata = ((i_reg_addr - REG_PTR0_HI) & 4'h1) != 4'h0 ?
							ptr[(i_reg_addr - REG_PTR0_HI) >> 1][7:0] :
							{4'h0, ptr[(i_reg_addr - REG_PTR0_HI) >> 1][11:8]};
					end
				end
			endcase
		end
		case (qtr)
			QTR_1: begin
				next_ir = i_instr;
				next_ir_valid = i_instr_valid;
			end
			QTR_2: begin
				next_eff_addr = addr_calc;
				if (cur_op == OP_LIT_OR) begin
					next_result = ir[7:0];
				end
			end
			QTR_3: begin
				case (cur_op)
					OP_LIT_OR: next_result = wreg | result;
					OP_FILE_OR: next_result = wreg | mem_rd;
					OP_FILE_COPY: next_result = mem_rd;
					default: ;
				endcase
			end
			default: begin
				case (cur_op)
					OP_LIT_OR, OP_FILE_OR, OP_FILE_COPY: begin
						if (cur_op == OP_LIT_OR || !fi.dest) begin
							next_wreg = result;
						end
						next_status[ST_N] = result[7];
						next_status[ST_Z] = (result == 8'h00);
					end
					OP_PTR_LOAD: begin
						next_ptr_idx = ir[5:4];
						next_seq = SEQ_SECOND;
						if (ir[5:4] != PTR_IDX_BAD) begin
							next_ptr[ir[5:4]][11:8] = ir[3:0];
						end
					end
					default: ;
				endcase
				if (seq == SEQ_SECOND) begin
					next_seq = SEQ_FIRST;
					if (ir_valid && ir[15:8] == PTR_SECOND_HI && ptr_idx != PTR_IDX_BAD) begin
						next_ptr[ptr_idx][7:0] = ir[7:0];
					end
				end
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			qtr <= QTR_1;
			ir <= 16'h0000;
			ir_valid <= 1'b0;
			seq <= SEQ_FIRST;
			ptr_idx <= 2'h0;
			result <= 8'h00;
			eff_addr <= 12'h000;
			wreg <= W_RESET;
			status <= STATUS_RESET;
			bank_select_register <= BANK_RESET;
			ptr <= {PTR_COUNT{PTR_RESET}};
			maddr <= 12'h000;
			rdata <= 8'h00;
		end else begin
			qtr <= next_qtr;
			ir <= next_ir;
			ir_valid <= next_ir_valid;
			seq <= next_seq;
			ptr_idx <= next_ptr_idx;
			result <= next_result;
			eff_addr <= next_eff_addr;
			wreg <= next_wreg;
			status <= next_status;
			bank_select_register <= next_bank_select_register;
			ptr <= next_ptr;
			maddr <= next_maddr;
			rdata <= next_rdata;
		end
	end

	assign o_reg_rdata = rdata;
	assign o_quarter = qtr;
	assign o_second_word = seq;
	assign o_wreg = wreg;
	assign o_status = status;
	assign o_bank_select = bank_select_register;
	assign o_ptr = ptr;

	//////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_q4_of(op_t op);
		qtr == QTR_4 && cur_op == op && !i_reg_wr;
	endsequence

	property p_lit_or;
		qtr == QTR_2 && cur_op == OP_LIT_OR && !i_reg_wr ##1 !i_reg_wr ##1 !i_reg_wr
			|=> wreg == ($past(wreg, 3) | ir[7:0]);
	endproperty
	a_lit_or: assert property (p_lit_or) else $error("literal or result wrong");

	property p_file_or_combine;
		qtr == QTR_3 && cur_op == OP_FILE_OR |=> result == ($past(wreg) | $past(mem_rd));
	endproperty
	a_file_or_combine: assert property (p_file_or_combine) else $error("file or combine wrong");

	property p_dest;
		s_q4_of(OP_FILE_OR) |-> (mem_we == fi.dest) ##1 (fi.dest ? $stable(wreg) : wreg == $past(result));
	endproperty
	a_dest: assert property (p_dest) else $error("file or destination wrong");

	property p_bank;
		mem_re |-> (fi.bank ? addr_calc[11:8] == bank_select_register :
			(addr_calc[11:8] == ACCESS_LOW_BANK) != fi.faddr[7]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank selection wrong");

	property p_flags;
		s_q4_of(OP_FILE_OR) |=> status[ST_N] == $past(result[7]) && status[ST_Z] == ($past(result) == 8'h00)
			&& status[ST_C] == $past(status[ST_C]) && status[3] == $past(status[3]) && status[1] == $past(status[1]);
	endproperty
	a_flags: assert property (p_flags) else $error("file or flags wrong");

	sequence s_ptr_first;
		s_q4_of(OP_PTR_LOAD) ##0 ir[5:4] != PTR_IDX_BAD;
	endsequence

	property p_ptr_high;
		s_ptr_first |=> ptr[ptr_idx][11:8] == $past(ir[3:0]) && seq == SEQ_SECOND;
	endproperty
	a_ptr_high: assert property (p_ptr_high) else $error("pointer high bits not loaded");

	property p_ptr_low;
		qtr == QTR_4 && seq == SEQ_SECOND && ir_valid && ir[15:8] == PTR_SECOND_HI && ptr_idx != PTR_IDX_BAD
			|=> ptr[ptr_idx][7:0] == $past(ir[7:0]) && seq == SEQ_FIRST;
	endproperty
	a_ptr_low: assert property (p_ptr_low) else $error("pointer low byte not loaded");

	property p_ptr_flags;
		s_q4_of(OP_PTR_LOAD) |=> $stable(status) [*4];
	endproperty
	a_ptr_flags: assert property (p_ptr_flags) else $error("pointer load touched flags");

	property p_copy;
		s_q4_of(OP_FILE_COPY) ##0 !fi.dest
			|=> wreg == $past(result) && status[ST_Z] == ($past(result) == 8'h00);
	endproperty
	a_copy: assert property (p_copy) else $error("file copy wrong");

	property p_read_quarter;
		mem_re |-> qtr == QTR_2 ##2 qtr == QTR_4 && mem_we == fi.dest && eff_addr == $past(addr_calc, 2);
	endproperty
	a_read_quarter: assert property (p_read_quarter) else $error("operand read outside second quarter");

	property p_bad_idx;
		s_q4_of(OP_PTR_LOAD) ##0 ir[5:4] == PTR_IDX_BAD |=> $stable(ptr) [*5];
	endproperty
	a_bad_idx: assert property (p_bad_idx) else $error("index 3 changed a pointer");
endmodule

// [or_move_pointer_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants and types of the or/move/pointer-load execute block
// Assumes: 16-bit instruction words, 8-bit data, 4096-byte data space
// Notes: register port indices address 8-bit registers
//////////////////////////////////////////////////////////////////////////////
package or_move_pointer_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int PTR_COUNT = 3;
	localparam int REG_AW = 4;

	// opcode patterns
	localparam logic [7:0] LIT_OR_HI = 8'h09;
	localparam logic [5:0] FILE_OR_HI = 6'h04;
	localparam logic [5:0] FILE_COPY_HI = 6'h14;
	localparam logic [9:0] PTR_LOAD_HI = 10'h3B8;
	localparam logic [7:0] PTR_SECOND_HI = 8'hF0;
	localparam logic [1:0] PTR_IDX_BAD = 2'h3;

	// fixed access region split: file addresses below go to bank 0, others to the top bank
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

	// quarter phases
	localparam logic [1:0] QTR_1 = 2'h0;
	localparam logic [1:0] QTR_2 = 2'h1;
	localparam logic [1:0] QTR_3 = 2'h2;
	localparam logic [1:0] QTR_4 = 2'h3;

	// status bit positions
	localparam int ST_C = 0;
	localparam int ST_Z = 2;
	localparam int ST_N = 4;
	localparam int ST_W = 5;

	// reset values
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [4:0] STATUS_RESET = 5'h00;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [11:0] PTR_RESET = 12'h000;

	// register port indices
	localparam logic [3:0] REG_BANK = 4'h0;
	localparam logic [3:0] REG_W = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_PTR0_HI = 4'h3;
	localparam logic [3:0] REG_PTR2_LO = 4'h8;
	localparam logic [3:0] REG_MADDR_LO = 4'h9;
	localparam logic [3:0] REG_MADDR_HI = 4'hA;
	localparam logic [3:0] REG_MDATA = 4'hB;

	typedef logic [PTR_COUNT-1:0][ADDR_W-1:0] ptr_bank_t;

	typedef struct packed {
		logic [5:0] opc;
		logic dest;
		logic bank;
		logic [7:0] faddr;
	} file_instr_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_LIT_OR = 3'h1,
		OP_FILE_OR = 3'h3,
		OP_FILE_COPY = 3'h2,
		OP_PTR_LOAD = 3'h6
	} op_t;

	typedef enum logic {
		SEQ_FIRST = 1'b0,
		SEQ_SECOND = 1'b1
	} seq_t;
endpackage

// [data_store.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: data memory with registered read and two write ports
// Assumes: single clock; write port b wins on a same-address collision
// Notes: array itself has no reset
//////////////////////////////////////////////////////////////////////////////
module data_store #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	input wire logic i_clk,
	input wire logic i_rd_en,
	input wire logic [AW-1:0] i_rd_addr,
	output logic [DW-1:0] o_rd_data,
	input wire logic i_wa_en,
	input wire logic [AW-1:0] i_wa_addr,
	input wire logic [DW-1:0] i_wa_data,
	input wire logic i_wb_en,
	input wire logic [AW-1:0] i_wb_addr,
	input wire logic [DW-1:0] i_wb_data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge i_clk) begin
		if (i_rd_en) begin
			o_rd_data <= mem[i_rd_addr];
		end
		if (i_wa_en) begin
			mem[i_wa_addr] <= i_wa_data;
		end
		if (i_wb_en) begin
			mem[i_wb_addr] <= i_wb_data;
		end
	end
endmodule

// [tb_or_move_pointer_load_exec.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench of the or/move/pointer-load execute block
// Assumes: instructions issued one per four-clock cycle, registers via port
// Notes: bench keeps its own model of W, status, bank select, memory, pointers
//////////////////////////////////////////////////////////////////////////////
module tb_or_move_pointer_load_exec
	import or_move_pointer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk, i_resetn, i_instr_valid, i_reg_wr, i_reg_rd, o_second_word;
	logic [15:0] i_instr;
	logic [REG_AW-1:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata, o_wreg;
	logic [1:0] o_quarter;
	logic [ST_W-1:0] o_status;
	logic [3:0] o_bank_select;
	ptr_bank_t o_ptr;
	int err_count, checks;
	logic [31:0] seed;
	logic [7:0] w, mem [0:4095];
	logic [4:0] st;
	logic [3:0] bank_model;
	logic [11:0] ptr [0:2];

	or_move_pointer_load_exec u_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_instr_valid(i_instr_valid),
		.i_instr(i_instr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_quarter(o_quarter), .o_second_word(o_second_word),
		.o_wreg(o_wreg), .o_status(o_status), .o_bank_select(o_bank_select), .o_ptr(o_ptr));

	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end

	//////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rand_step(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction

	function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f, input logic [3:0] b);
		if (a)
			return {b, f};
		return (f < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, f} : {ACCESS_HIGH_BANK, f};
	endfunction

	task automatic rnd(output logic [31:0] v);
		seed = rand_step(seed);
		v = seed;
	endtask

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
		@(negedge i_sys_clk);
		d = o_reg_rdata;
	endtask

	task automatic wait_q(input logic [1:0] q);
		int n;
		n = 0;
		@(negedge i_sys_clk);
		while (o_quarter !== q && n < 20) begin
			@(negedge i_sys_clk);
			n++;
		end
		if (n >= 20)
			err_count++;
	endtask

	task automatic issue(input logic [15:0] word);
		@(posedge i_sys_clk);
		i_instr <= word;
		i_instr_valid <= 1'b1;
		wait_q(QTR_1);
		wait_q(QTR_2);
	endtask

	task automatic finish();
		@(posedge i_sys_clk);
		i_instr_valid <= 1'b0;
		wait_q(QTR_1);
	endtask

	task automatic set_nz(input logic [7:0] v);
		st[ST_N] = v[7];
		st[ST_Z] = (v == 8'h00);
	endtask

	task automatic preset(input logic [7:0] wv, input logic [4:0] sv, input logic [3:0] bv);
		w = wv;
		st = sv;
		bank_model = bv;
		wr(REG_W, wv);
		wr(REG_STATUS, {3'h0, sv});
		wr(REG_BANK, {4'h0, bv});
	endtask

	task automatic put_mem(input logic [11:0] a, input logic [7:0] v);
		mem[a] = v;
		wr(REG_MADDR_LO, a[7:0]);
		wr(REG_MADDR_HI, {4'h0, a[11:8]});
		wr(REG_MDATA, v);
	endtask

	task automatic lit_or(input logic [7:0] k);
		issue({LIT_OR_HI, k});
		finish();
		w = w | k;
		set_nz(w);
		chk(o_wreg, w);
		chk(o_status, st);
	endtask

	task automatic file_op(input logic cp, input logic d, input logic a, input logic [7:0] f);
		logic [11:0] ea;
		logic [7:0] res;
		ea = eff_addr(a, f, bank_model);
		res = cp ? mem[ea] : (w | mem[ea]);
		issue({cp ? FILE_COPY_HI : FILE_OR_HI, d, a, f});
		finish();
		if (d)
			mem[ea] = res;
		else
			w = res;
		set_nz(res);
		chk(o_wreg, w);
		chk(o_status, st);
	endtask

	task automatic ptr_load(input logic [1:0] idx, input logic [11:0] k, input logic [7:0] hi2);
		logic [11:0] mid;
		issue({PTR_LOAD_HI, idx, k[11:8]});
		issue({hi2, k[7:0]});
		chk(o_second_word, 1'b1);
		if (idx != PTR_IDX_BAD) begin
			mid = {k[11:8], ptr[idx][7:0]};
			chk(o_ptr[idx], mid);
			ptr[idx] = (hi2 == PTR_SECOND_HI) ? k : mid;
		end
		finish();
		chk(o_second_word, 1'b0);
		for (int i = 0; i < PTR_COUNT; i++)
			chk(o_ptr[i], ptr[i]);
		chk(o_status, st);
	endtask

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end

	initial begin
		logic [31:0] r, r2;
		logic [7:0] d;
		seed = 32'h3D8FCA0A;
		err_count = 0;
		checks = 0;
		i_resetn = 1'b0;
		i_instr_valid = 1'b0;
		i_instr = 16'h0000;
		i_reg_addr = 4'h0;
		i_reg_wdata = 8'h00;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		w = 8'h00;
		st = 5'h00;
		bank_model = 4'h0;
		for (int i = 0; i < 3; i++)
			ptr[i] = 12'h000;
		repeat (6) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		chk({o_wreg, o_status, o_bank_select}, 36'h0);
		chk(o_ptr, 36'h0);
		$display("test reset done");

		preset(8'h9A, 5'h1F, 4'h5);
		rd(REG_BANK, d);
		chk(d, 8'h05);
		rd(4'hD, d);
		chk(d, 8'h00);
		rd(REG_MDATA, d);
		chk(d, 8'h00);
		wr(REG_PTR0_HI, 8'hFF);
		@(negedge i_sys_clk);
		chk(o_ptr, 36'h0);
		$display("test register port done");

		lit_or(8'h35);
		preset(8'h00, 5'h0B, 4'h0);
		lit_or(8'h00);
		preset(8'h91, 5'h00, 4'h3);
		put_mem(12'h013, 8'h13);
		file_op(1'b0, 1'b0, 1'b0, 8'h13);
		put_mem(12'hFF0, 8'h22);
		file_op(1'b1, 1'b0, 1'b0, 8'hF0);
		$display("test corner cases done");

		for (int n = 0; n < 60; n++) begin
			rnd(r);
			rnd(r2);
			preset(r[7:0], r[12:8], r[16:13]);
			if (r2[1:0] == 2'h0) begin
				lit_or(r2[15:8]);
			end else begin
				put_mem(eff_addr(r2[2], r2[15:8], bank_model), r2[23:16]);
				file_op(r2[0], r2[3], r2[2], r2[15:8]);
				if (r2[3])
					file_op(1'b1, 1'b0, r2[2], r2[15:8]);
			end
		end
		$display("test random ops done");

		for (int i = 0; i < 4; i++) begin
			rnd(r);
			ptr_load(i[1:0], r[11:0], PTR_SECOND_HI);
			ptr_load(i[1:0], ~r[11:0], PTR_SECOND_HI);
		end
		ptr_load(2'h1, 12'h3AB, 8'hA5);
		ptr_load(2'h2, 12'h3AB, PTR_SECOND_HI);
		rd(REG_PTR2_LO, d);
		chk(d, ptr[2][7:0]);
		rd(REG_PTR0_HI, d);
		chk(d, {4'h0, ptr[0][11:8]});
		$display("test pointer load done");
		wrap_up();
	end
endmodule
